// ===== bcs_pkg.sv
// package: constants and types for breaker command/status cells
package bcs_pkg;

  // ****************************************************
  // cell addresses of the data array
  // ****************************************************
  localparam logic [2:0] CELL_COMMAND     = 3'h0;
  localparam logic [2:0] CELL_LINK_LOW    = 3'h1;
  localparam logic [2:0] CELL_LINK_HIGH   = 3'h2;
  localparam logic [2:0] CELL_TRIP        = 3'h3;
  localparam logic [2:0] CELL_ALARM       = 3'h4;
  localparam logic [2:0] CELL_PHASE       = 3'h5;
  localparam logic [2:0] CELL_DIAG_RECORD = 3'h6;

  // ****************************************************
  // command codes
  // ****************************************************
  localparam logic [7:0] CMD_DIAG_FIRST = 8'h10;
  localparam logic [7:0] CMD_DIAG_LAST  = 8'h19;
  localparam logic [7:0] CMD_DIAG_EXIT  = 8'h1A;
  localparam logic [7:0] CMD_ACK_STOP   = 8'h22;
  localparam logic [7:0] CMD_TRIP       = 8'h35;

  // connection setup identifiers from the breaker side
  localparam logic [7:0] SETUP_ID_BREAKER = 8'h01;
  localparam logic [7:0] SETUP_ID_BLOCK   = 8'h1E;
  localparam logic [7:0] SETUP_ID_XFER    = 8'h3F;

  // ****************************************************
  // field positions and reset values
  // ****************************************************
  localparam int         LINK0_NEW_SERIAL  = 0;
  localparam int         LINK0_PARAM_DIFF  = 1;
  localparam int         LINK0_MOTOR_MISM  = 2;
  localparam int         LINK0_WAIT_ID     = 5;
  localparam int         LINK0_WAIT_BLOCK  = 6;
  localparam int         LINK0_WAIT_XFER   = 7;
  localparam int         LINK1_DIAG_DATA   = 4;
  localparam int         TRIP_INSTANT      = 0;
  localparam int         TRIP_SHORT_DELAY  = 1;
  localparam int         TRIP_LONG_DELAY   = 2;
  localparam int         TRIP_RESIDUAL     = 3;
  localparam int         TRIP_COMM         = 5;
  localparam int         TRIP_OVERTEMP     = 6;
  localparam logic [7:0] CELL_RESET        = 8'h00;
  localparam logic [2:0] SETUP_WAIT_RESET  = 3'h7;
  localparam int         DIAG_RECORDS      = 10;
  localparam int         EXEC_CYCLES       = 4;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [3:0] {
    CMD_IDLE   = 4'b0001,
    CMD_ECHO   = 4'b0010,
    CMD_INVERT = 4'b0100,
    CMD_EXEC   = 4'b1000
  } bcs_cmd_state_type;

  // breaker-side condition inputs
  typedef struct packed {
    logic       newSerialInStop;
    logic       paramDiffer;
    logic       motorParamMismatch;
    logic       diagDataLatest;
    logic [3:0] lastRecordIndex;
  } bcs_link_cond_type;

  typedef struct packed {
    logic instantaneousTrip;
    logic shortDelayTrip;
    logic longDelayTrip;
    logic residualCurrentTrip;
    logic commTrip;
    logic overTempTrip;
  } bcs_trip_cond_type;

endpackage : bcs_pkg

// ===== bcs_record_mem.sv
// small memory of diagnostic records with registered read data
module bcs_record_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 10,
  parameter int AW    = 4
) (
  input  wire logic             core_clk,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] memArray [DEPTH];

  // write port and registered read
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      memArray[wrAddr] <= wrData;
    end
    rdData <= memArray[rdAddr];
  end

endmodule : bcs_record_mem

// ===== bcs_cells.sv
// command cell interpreter and status cells of the breaker interface
module bcs_cells #(
  parameter int DATA_W  = 8,
  parameter int RECORDS = bcs_pkg::DIAG_RECORDS
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic                       cellWrite,
  input  wire logic                       cellRead,
  input  wire logic [2:0]                 cellAddr,
  input  wire logic [DATA_W-1:0]          cellWrData,
  output logic      [DATA_W-1:0]          cellRdData,
  input  wire logic                       setupByteValid,
  input  wire logic [7:0]                 setupByte,
  input  wire logic                       startupStopPin,
  input  wire bcs_pkg::bcs_link_cond_type linkCond,
  input  wire bcs_pkg::bcs_trip_cond_type tripCond,
  input  wire logic [7:0]                 alarmCond,
  input  wire logic [7:0]                 phaseCond,
  input  wire logic [7:0]                 processData,
  input  wire logic                       recordWrite,
  input  wire logic [3:0]                 recordWrIndex,
  input  wire logic [7:0]                 recordWrData,
  output logic                            breakerTrip,
  output logic                            serialAccept,
  output logic                            diagMode
);

  // ****************************************************
  // pin synchroniser for startup stop (three stages)
  // ****************************************************
  logic [2:0] stopSync_reg;
  logic [2:0] stopSync_next;
  logic       stopActive_reg;
  logic       stopActive_next;

  // shift and accept once stages two and three agree
  always_comb begin
    stopSync_next   = {stopSync_reg[1:0], startupStopPin};
    stopActive_next = stopActive_reg;
    if (stopSync_reg[1] == stopSync_reg[2]) begin
      stopActive_next = stopSync_reg[2];
    end
  end

  // synchroniser stages and filtered level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stopSync_reg   <= 3'h0;
      stopActive_reg <= 1'b0;
    end else begin
      stopSync_reg   <= stopSync_next;
      stopActive_reg <= stopActive_next;
    end
  end

  // ****************************************************
  // command cell state machine
  // ****************************************************
  bcs_pkg::bcs_cmd_state_type state_reg;
  bcs_pkg::bcs_cmd_state_type state_next;
  logic [7:0] cmdCell_reg;
  logic [7:0] cmdCell_next;
  logic [2:0] execCnt_reg;
  logic [2:0] execCnt_next;
  logic       diag_reg;
  logic       diag_next;
  logic [3:0] selRecord_reg;
  logic [3:0] selRecord_next;
  logic       trip_reg;
  logic       trip_next;
  logic       accept_reg;
  logic       accept_next;
  logic       cmdWrite;

  assign cmdWrite = cellWrite && (cellAddr == bcs_pkg::CELL_COMMAND);

  // ****************************************************
  // decode of the code held in the cell
  // ****************************************************
  logic [7:0] heldCode;
  logic       codeDiagSel;
  logic       codeDiagExit;
  logic       codeAckStop;
  logic       codeTrip;

  // cell holds the inverse while executing, so undo it
  always_comb begin
    heldCode     = ~cmdCell_reg;
    codeDiagSel  = (heldCode >= bcs_pkg::CMD_DIAG_FIRST) &&
                   (heldCode <= bcs_pkg::CMD_DIAG_LAST);
    codeDiagExit = (heldCode == bcs_pkg::CMD_DIAG_EXIT);
    codeAckStop  = (heldCode == bcs_pkg::CMD_ACK_STOP);
    codeTrip     = (heldCode == bcs_pkg::CMD_TRIP);
  end

  // echo, invert, execute, clear
  always_comb begin
    state_next     = state_reg;
    cmdCell_next   = cmdCell_reg;
    execCnt_next   = execCnt_reg;
    diag_next      = diag_reg;
    selRecord_next = selRecord_reg;
    trip_next      = 1'b0;
    accept_next    = 1'b0;
    case (state_reg)
      bcs_pkg::CMD_IDLE: begin
        if (cmdWrite) begin
          cmdCell_next = cellWrData[7:0];
          state_next   = bcs_pkg::CMD_ECHO;
        end
      end
      bcs_pkg::CMD_ECHO: begin
        // recognition: any code is taken as defined
        cmdCell_next = ~cmdCell_reg;
        execCnt_next = 3'(bcs_pkg::EXEC_CYCLES);
        state_next   = bcs_pkg::CMD_INVERT;
      end
      bcs_pkg::CMD_INVERT: begin
        if (execCnt_reg != 3'h0) begin
          execCnt_next = execCnt_reg - 3'h1;
        end else begin
          state_next = bcs_pkg::CMD_EXEC;
        end
      end
      bcs_pkg::CMD_EXEC: begin
        if (codeDiagSel) begin
          diag_next      = 1'b1;
          selRecord_next = 4'(heldCode - bcs_pkg::CMD_DIAG_FIRST);
        end else if (codeDiagExit) begin
          diag_next = 1'b0;
        end else if (codeAckStop) begin
          accept_next = stopActive_reg;
        end else if (codeTrip) begin
          trip_next = 1'b1;
        end
        cmdCell_next = bcs_pkg::CELL_RESET;
        state_next   = bcs_pkg::CMD_IDLE;
      end
      default: begin
        state_next   = bcs_pkg::CMD_IDLE;
        cmdCell_next = bcs_pkg::CELL_RESET;
      end
    endcase
  end

  // state and command cell registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= bcs_pkg::CMD_IDLE;
      cmdCell_reg   <= bcs_pkg::CELL_RESET;
      execCnt_reg   <= 3'h0;
      diag_reg      <= 1'b0;
      selRecord_reg <= 4'h0;
      trip_reg      <= 1'b0;
      accept_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cmdCell_reg   <= cmdCell_next;
      execCnt_reg   <= execCnt_next;
      diag_reg      <= diag_next;
      selRecord_reg <= selRecord_next;
      trip_reg      <= trip_next;
      accept_reg    <= accept_next;
    end
  end

  // ****************************************************
  // connection setup flags of status byte 0
  // ****************************************************
  logic [2:0] setupWait_reg;
  logic [2:0] setupWait_next;

  // each flag drops on its own setup identifier
  always_comb begin
    setupWait_next = setupWait_reg;
    if (setupByteValid) begin
      if (setupByte == bcs_pkg::SETUP_ID_BREAKER) begin
        setupWait_next[0] = 1'b0;
      end
      if (setupByte == bcs_pkg::SETUP_ID_BLOCK) begin
        setupWait_next[1] = 1'b0;
      end
      if (setupByte == bcs_pkg::SETUP_ID_XFER) begin
        setupWait_next[2] = 1'b0;
      end
    end
  end

  // setup flags, all set out of reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      setupWait_reg <= bcs_pkg::SETUP_WAIT_RESET;
    end else begin
      setupWait_reg <= setupWait_next;
    end
  end

  // ****************************************************
  // diagnostic record store
  // ****************************************************
  logic [7:0] recordData;
  logic       recordWrOk;

  // indices past the last record are dropped
  assign recordWrOk = recordWrite && (recordWrIndex < 4'(RECORDS));

  bcs_record_mem #(
    .WIDTH (8),
    .DEPTH (RECORDS),
    .AW    (4)
  ) recordMem (
    .core_clk (core_clk),
    .wrEn     (recordWrOk),
    .wrAddr   (recordWrIndex),
    .wrData   (recordWrData),
    .rdAddr   (selRecord_reg),
    .rdData   (recordData)
  );

  // ****************************************************
  // status bytes and read mux
  // ****************************************************
  logic [7:0] linkLow;
  logic [7:0] linkHigh;
  logic [7:0] tripByte;
  logic [7:0] procHeld_reg;
  logic [7:0] procHeld_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  // status bits are one when condition true
  always_comb begin
    linkLow = 8'h00;
    linkLow[bcs_pkg::LINK0_NEW_SERIAL] = linkCond.newSerialInStop;
    linkLow[bcs_pkg::LINK0_PARAM_DIFF] = linkCond.paramDiffer;
    linkLow[bcs_pkg::LINK0_MOTOR_MISM] = linkCond.motorParamMismatch;
    linkLow[bcs_pkg::LINK0_WAIT_ID]    = setupWait_reg[0];
    linkLow[bcs_pkg::LINK0_WAIT_BLOCK] = setupWait_reg[1];
    linkLow[bcs_pkg::LINK0_WAIT_XFER]  = setupWait_reg[2];
    linkHigh = 8'h00;
    linkHigh[3:0] = linkCond.lastRecordIndex;
    linkHigh[bcs_pkg::LINK1_DIAG_DATA] = linkCond.diagDataLatest;
    tripByte = 8'h00;
    tripByte[bcs_pkg::TRIP_INSTANT]     = tripCond.instantaneousTrip;
    tripByte[bcs_pkg::TRIP_SHORT_DELAY] = tripCond.shortDelayTrip;
    tripByte[bcs_pkg::TRIP_LONG_DELAY]  = tripCond.longDelayTrip;
    tripByte[bcs_pkg::TRIP_RESIDUAL]    = tripCond.residualCurrentTrip;
    tripByte[bcs_pkg::TRIP_COMM]        = tripCond.commTrip;
    tripByte[bcs_pkg::TRIP_OVERTEMP]    = tripCond.overTempTrip;
  end

  // process data frozen while in diagnostics mode
  always_comb begin
    procHeld_next = diag_reg ? procHeld_reg : processData;
  end

  // held process data register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      procHeld_reg <= 8'h00;
    end else begin
      procHeld_reg <= procHeld_next;
    end
  end

  // ****************************************************
  // registered read of the addressed cell
  // ****************************************************
  // one cell per read strobe, held until the next
  always_comb begin
    rdData_next = rdData_reg;
    if (cellRead) begin
      case (cellAddr)
        bcs_pkg::CELL_COMMAND:     rdData_next = cmdCell_reg;
        bcs_pkg::CELL_LINK_LOW:    rdData_next = linkLow;
        bcs_pkg::CELL_LINK_HIGH:   rdData_next = linkHigh;
        bcs_pkg::CELL_TRIP:        rdData_next = tripByte;
        bcs_pkg::CELL_ALARM:       rdData_next = alarmCond;
        bcs_pkg::CELL_PHASE:       rdData_next = phaseCond;
        bcs_pkg::CELL_DIAG_RECORD: rdData_next = diag_reg ? recordData : procHeld_reg;
        default:                   rdData_next = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // outputs straight from flip-flops
  assign cellRdData   = DATA_W'(rdData_reg);
  assign breakerTrip  = trip_reg;
  assign serialAccept = accept_reg;
  assign diagMode     = diag_reg;

endmodule : bcs_cells

// ===== bcs_cells_props.sv
// checker: command cell handshake, output pulses and trip cell contents
module bcs_cells_props #(parameter int DATA_W = 8) (
  input wire logic                       core_clk,
  input wire logic                       reset_n,
  input wire logic                       cellWrite,
  input wire logic                       cellRead,
  input wire logic [2:0]                 cellAddr,
  input wire logic [DATA_W-1:0]          cellWrData,
  input wire logic [DATA_W-1:0]          cellRdData,
  input wire bcs_pkg::bcs_trip_cond_type tripCond,
  input wire logic                       breakerTrip,
  input wire logic                       serialAccept,
  input wire logic                       diagMode
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] code_reg;
  logic [7:0] code_next;
  logic       take;
  logic [7:0] tripByte;
  logic       rd0;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // command accepted only when the tracker sees no sequence running
  assign take     = cellWrite && cellAddr == 3'h0 && cnt_reg <= 4'h1;
  assign rd0      = cellRead && cellAddr == 3'h0;
  assign tripByte = {1'b0, tripCond[0], tripCond[1], 1'b0,
                     tripCond[2], tripCond[3], tripCond[4], tripCond[5]};
  // busy count and code of the last accepted command
  always_comb begin
    cnt_next  = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
    code_next = code_reg;
    if (take) begin
      cnt_next  = 4'h8;
      code_next = cellWrData[7:0];
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg  <= 4'h0;
      code_reg <= 8'h00;
    end else begin
      cnt_reg  <= cnt_next;
      code_reg <= code_next;
    end
  end
  a_cmd_echo: assert property (
    rd0 && cnt_reg == 4'h8 |=> cellRdData[7:0] == code_reg) else $error("no echo");
  a_cmd_invert: assert property (
    rd0 && cnt_reg inside {[3:6]} |=> cellRdData[7:0] == ~code_reg) else $error("no inverse");
  a_cmd_clear: assert property (
    rd0 && !cellWrite && cnt_reg == 4'h0 |=> cellRdData[7:0] == 8'h00) else $error("not cleared");
  a_trip_cause: assert property (
    breakerTrip |-> code_reg == 8'h35 && cnt_reg inside {[1:3]}) else $error("stray trip");
  a_accept_cause: assert property (
    serialAccept |-> code_reg == 8'h22 && cnt_reg inside {[1:3]}) else $error("stray accept");
  a_diag_enter: assert property (
    take && cellWrData[7:0] inside {[8'h10:8'h19]} |-> ##[6:9] diagMode) else $error("no diag");
  a_diag_exit: assert property (
    $fell(diagMode) |-> code_reg == 8'h1A && cnt_reg inside {[1:3]}) else $error("bad exit");
  a_trip_cell: assert property (
    cellRead && cellAddr == 3'h3 |=> cellRdData[7:0] == $past(tripByte)) else $error("trip cell");
endmodule : bcs_cells_props

bind bcs_cells bcs_cells_props #(.DATA_W(DATA_W)) props_u (
  .core_clk(core_clk), .reset_n(reset_n), .cellWrite(cellWrite), .cellRead(cellRead),
  .cellAddr(cellAddr), .cellWrData(cellWrData), .cellRdData(cellRdData),
  .tripCond(tripCond), .breakerTrip(breakerTrip), .serialAccept(serialAccept),
  .diagMode(diagMode)
);

// ===== bcs_master_model.sv
// fieldbus master model: cell reads and command writes
module bcs_master_model (
  input  wire logic       core_clk,
  output logic            cellWrite,
  output logic            cellRead,
  output logic [2:0]      cellAddr,
  output logic [7:0]      cellWrData,
  input  wire logic [7:0] cellRdData
);
  initial begin
    cellWrite  = 1'b0;
    cellRead   = 1'b0;
    cellAddr   = 3'h0;
    cellWrData = 8'h00;
  end
  // one read; data is taken one edge after the request
  task automatic rd_cell(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    cellRead <= 1'b1;
    cellAddr <= a;
    @(posedge core_clk);
    cellRead <= 1'b0;
    cellAddr <= ~a;
    @(negedge core_clk);
    d = cellRdData;
  endtask : rd_cell
  // write a code to cell 0, then read it every cycle until cleared
  task automatic issue(input logic [7:0] c, output logic [7:0] f, output logic v,
                       output logic [7:0] l);
    v = 1'b0;
    f = 8'h00;
    l = 8'hFF;
    @(posedge core_clk);
    cellWrite  <= 1'b1;
    cellAddr   <= 3'h0;
    cellWrData <= c;
    @(posedge core_clk);
    cellWrite  <= 1'b0;
    cellWrData <= ~c;
    cellRead   <= 1'b1;
    for (int k = 0; k < 20 && l !== 8'h00; k++) begin
      @(posedge core_clk);
      @(negedge core_clk);
      l = cellRdData;
      if (k == 0) f = l;
      v = v | (l === ~c);
    end
    @(posedge core_clk);
    cellRead <= 1'b0;
    cellAddr <= 3'h7;
  endtask : issue
endmodule : bcs_master_model

// ===== test_breaker_command_status_cells.sv
// testbench: command handshake, diagnostics mode and status cells
module test_breaker_command_status_cells;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       core_clk, reset_n, cellWrite, cellRead, setupByteValid;
  logic                       startupStopPin, recordWrite, breakerTrip, serialAccept, diagMode;
  logic [2:0]                 cellAddr;
  logic [3:0]                 recordWrIndex;
  logic [7:0]                 cellWrData, cellRdData, setupByte, alarmCond, phaseCond;
  logic [7:0]                 processData, recordWrData;
  bcs_pkg::bcs_link_cond_type linkCond;
  bcs_pkg::bcs_trip_cond_type tripCond;
  int                         n_mismatch = 0, n_tests = 0, tripCnt = 0, acceptCnt = 0;
  bcs_cells dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .cellWrite(cellWrite), .cellRead(cellRead),
    .cellAddr(cellAddr), .cellWrData(cellWrData), .cellRdData(cellRdData),
    .setupByteValid(setupByteValid), .setupByte(setupByte), .startupStopPin(startupStopPin),
    .linkCond(linkCond), .tripCond(tripCond), .alarmCond(alarmCond), .phaseCond(phaseCond),
    .processData(processData), .recordWrite(recordWrite), .recordWrIndex(recordWrIndex),
    .recordWrData(recordWrData), .breakerTrip(breakerTrip), .serialAccept(serialAccept),
    .diagMode(diagMode));
  bcs_master_model master_u (
    .core_clk(core_clk), .cellWrite(cellWrite), .cellRead(cellRead), .cellAddr(cellAddr),
    .cellWrData(cellWrData), .cellRdData(cellRdData));
  // clock and pulse counters
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (breakerTrip === 1'b1) tripCnt++;
    if (serialAccept === 1'b1) acceptCnt++;
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // issue a command and judge the cell 0 handshake
  task automatic run_cmd(input logic [7:0] c);
    logic [7:0] f;
    logic [7:0] l;
    logic       v;
    master_u.issue(c, f, v, l);
    chk8("echoed code", c, f);
    chk8("inverse seen", 8'h01, {7'h0, v});
    chk8("cleared cell", 8'h00, l);
    if (l !== 8'h00) final_report();
  endtask : run_cmd
  task automatic t_setup;
    logic [7:0] d;
    master_u.rd_cell(3'h1, d);
    chk8("status low at reset", 8'hE0, d);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      setupByteValid <= 1'b1;
      setupByte      <= (i == 0) ? 8'h01 : (i == 1) ? 8'h1E : 8'h3F;
      @(posedge core_clk);
      setupByteValid <= 1'b0;
      setupByte      <= 8'hAA;
      master_u.rd_cell(3'h1, d);
      chk8("status low setup", 8'(8'hE0 << (i + 1)), d);
    end
    master_u.rd_cell(3'h7, d);
    chk8("unmapped cell", 8'h00, d);
    $display("done: setup identifiers");
  endtask : t_setup
  task automatic t_status;
    logic [7:0] d;
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk);
      linkCond  <= p ? 8'h42 : 8'hB9;
      tripCond  <= p ? 6'h2A : 6'h3F;
      alarmCond <= p ? 8'h0A : 8'h15;
      phaseCond <= p ? 8'h1B : 8'hE4;
      repeat (2) @(posedge core_clk);
      master_u.rd_cell(3'h1, d);
      chk8("status low", p ? 8'h02 : 8'h05, d);
      master_u.rd_cell(3'h2, d);
      chk8("status high", p ? 8'h02 : 8'h19, d);
      master_u.rd_cell(3'h3, d);
      chk8("trip cell", p ? 8'h25 : 8'h6F, d);
      master_u.rd_cell(3'h4, d);
      chk8("alarm cell", p ? 8'h0A : 8'h15, d);
      master_u.rd_cell(3'h5, d);
      chk8("phase cell", p ? 8'h1B : 8'hE4, d);
    end
    $display("done: status cells");
  endtask : t_status
  task automatic t_cmds;
    int t0;
    t0 = tripCnt;
    run_cmd(8'h35);
    repeat (2) @(posedge core_clk);
    chk8("trip pulses", 8'h01, 8'(tripCnt - t0));
    run_cmd(8'h22);
    chk8("accept outside stop", 8'h00, 8'(acceptCnt));
    startupStopPin <= 1'b1;
    repeat (5) @(posedge core_clk);
    run_cmd(8'h22);
    repeat (2) @(posedge core_clk);
    chk8("accept in stop", 8'h01, 8'(acceptCnt));
    startupStopPin <= 1'b0;
    $display("done: trip and stop commands");
  endtask : t_cmds
  task automatic t_diag;
    logic [7:0] d;
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      recordWrite   <= 1'b1;
      recordWrIndex <= 4'(i);
      recordWrData  <= 8'(8'hA0 + i);
    end
    @(posedge core_clk);
    recordWrite <= 1'b0;
    master_u.rd_cell(3'h6, d);
    chk8("process data", 8'h11, d);
    for (int i = 0; i < 10; i++) begin
      run_cmd(8'(8'h10 + i));
      processData <= 8'h5A;
      chk8("diag mode on", 8'h01, {7'h0, diagMode});
      master_u.rd_cell(3'h6, d);
      master_u.rd_cell(3'h6, d);
      chk8("diag record", 8'(8'hA0 + i), d);
    end
    run_cmd(8'h1A);
    chk8("diag mode off", 8'h00, {7'h0, diagMode});
    master_u.rd_cell(3'h6, d);
    master_u.rd_cell(3'h6, d);
    chk8("fresh process data", 8'h5A, d);
    $display("done: diagnostics mode");
  endtask : t_diag
  // reset, then the scenarios in turn
  initial begin
    reset_n        = 1'b0;
    setupByteValid = 1'b0;
    setupByte      = 8'h00;
    startupStopPin = 1'b0;
    linkCond       = '0;
    tripCond       = '0;
    alarmCond      = 8'h00;
    phaseCond      = 8'h00;
    processData    = 8'h11;
    recordWrite    = 1'b0;
    recordWrIndex  = 4'h0;
    recordWrData   = 8'h00;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    t_setup();
    t_status();
    t_cmds();
    t_diag();
    final_report();
  end
endmodule : test_breaker_command_status_cells
